//--- core/rfc_pkg.sv
// Package: constants, map and carriers of the reference frequency counter
package rfc_pkg;
    // ========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned TICK_MS     = 4;
    localparam int unsigned NOREF_S     = 3;
    localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned NOREF_CYC   = CLK_HZ * NOREF_S;
    localparam int unsigned BAUD_OVS    = 16;
    localparam int unsigned BAUD_MIN    = 300;
    localparam int unsigned BAUD_MAX    = 19200;
    localparam int unsigned CNT_W       = 32;
    // ========================================================
    // Register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_CH1N   = 8'h04;
    localparam logic [7:0] A_COUNT  = 8'h08;
    localparam logic [7:0] A_STS    = 8'h0c;
    localparam logic [7:0] A_CLR    = 8'h10;
    localparam logic [7:0] A_IEN    = 8'h14;
    localparam logic [7:0] A_RXD    = 8'h18;
    localparam logic [7:0] A_LEVEL  = 8'h1c;
    // Control fields and reset values
    localparam int unsigned C_RUN    = 0;
    localparam int unsigned C_PERIOD = 1;
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [CNT_W-1:0] CH1N_RST = 32'h0000_03e8;
    // Event bits of status, clear and enable
    localparam int unsigned EV_W = 5;
    localparam logic [EV_W-1:0] EV_RST = 5'h00;
    // ========================================================
    // Event carrier, same layout as status/clear/enable
    typedef struct packed {
        logic overrun;
        logic noref;
        logic done;
        logic rx;
        logic tick;
    } rfc_evt_t;
    // Measurement sequencer
    typedef enum logic [0:0] {M_IDLE, M_GATE} rfc_mstate_t;
    // Switch code to x16 divisor; codes above 6 give 19200 baud
    function automatic logic [CNT_W-1:0] rfc_baud_div(input logic [2:0] sel,
                                                      input int unsigned hz);
        int unsigned rate;
        rate = BAUD_MIN << ((sel > 3'h6) ? 6 : int'(sel));
        if (rate > BAUD_MAX) rate = BAUD_MAX;
        return CNT_W'(hz / (BAUD_OVS * rate));
    endfunction
endpackage

//--- core/rfc_div.sv
// Programmable divide-by-N counter channel
`timescale 1ns/1ps
`default_nettype none
module rfc_div #(
    parameter int unsigned W = 32
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         run,
    input  wire logic [W-1:0] n,
    output var  logic         tick
);
    logic [W-1:0] cnt_q;
    // ========================================================
    // One pulse every n enabled cycles; n of 0 acts as 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q + W'(1) >= n) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- core/rfc_top.sv
// Reference frequency counter: measurement, baud clock, tick, APB slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - channel 2 gives x16 serial clock
// - switches pick baud 300 to 19200
// - channels 0,1 measure reference frequency or period
// - channel 0 counts only inside gate
// - gate: one reference period or fixed time
// - channel 1 divides by programmable N
// - tick interrupt every 4 ms
// - received byte raises ready, must be read
// - no-reference after 3 s without pulse
module rfc_top
    import rfc_pkg::*;
#(
    parameter int unsigned CLK_FREQ  = CLK_HZ,
    parameter int unsigned TICK_CNT  = TICK_CYC,
    parameter int unsigned NOREF_CNT = NOREF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        ref_in,
    input  wire logic [2:0]  baud_sw,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    output var  logic        baud_x16,
    output var  logic        receive_byte_ready,
    output var  logic        no_ref,
    output var  logic        irq
);
    // ========================================================
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] ref_s_q;
    logic [2:0] sw0_q, sw1_q, sw2_q;
    logic       ref_f_q, ref_p_q;
    logic [2:0] sw_f_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_s_q <= 3'h0;
            sw0_q   <= 3'h0;
            sw1_q   <= 3'h0;
            sw2_q   <= 3'h0;
        end else begin
            ref_s_q <= {ref_s_q[1:0], ref_in};
            sw0_q   <= baud_sw;
            sw1_q   <= sw0_q;
            sw2_q   <= sw1_q;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_f_q <= 1'b0;
            ref_p_q <= 1'b0;
            sw_f_q  <= 3'h0;
        end else begin
            if (ref_s_q[1] == ref_s_q[2]) ref_f_q <= ref_s_q[2];
            ref_p_q <= ref_f_q;
            if (sw1_q == sw2_q) sw_f_q <= sw2_q;
        end
    end
    wire ref_edge = ref_f_q & ~ref_p_q;

    // ========================================================
    // APB decode
    logic [1:0]       ctrl_q;
    logic [CNT_W-1:0] ch1n_q, hold_q, cnt_q;
    logic [EV_W-1:0]  sts_q, ien_q;
    logic [7:0]       rxd_q;
    rfc_mstate_t      mst_q;
    wire setup    = psel & ~penable;
    wire access   = psel & penable & pready;
    wire wr       = access & pwrite;
    wire rd_rxd   = access & ~pwrite & (paddr == A_RXD);
    wire hit      = (paddr == A_CTRL) | (paddr == A_CH1N) |
                    (paddr == A_COUNT) | (paddr == A_STS) |
                    (paddr == A_CLR) | (paddr == A_IEN) |
                    (paddr == A_RXD) | (paddr == A_LEVEL);
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            A_CTRL:  rd_mux = {30'h0, ctrl_q};
            A_CH1N:  rd_mux = ch1n_q;
            A_COUNT: rd_mux = hold_q;
            A_STS:   rd_mux = {27'h0, sts_q};
            A_IEN:   rd_mux = {27'h0, ien_q};
            A_RXD:   rd_mux = {24'h0, rxd_q};
            A_LEVEL: rd_mux = {29'h0, receive_byte_ready,
                               mst_q == M_GATE, no_ref};
            default: rd_mux = 32'h0;
        endcase
    end
    // Answer is ready in the first access cycle, one wait-free transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup) prdata <= pwrite ? 32'h0 : rd_mux;
        end
    end
    // Writable control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            ch1n_q <= CH1N_RST;
            ien_q  <= EV_RST;
        end else if (wr) begin
            if (paddr == A_CTRL) ctrl_q <= pwdata[1:0];
            if (paddr == A_CH1N) ch1n_q <= pwdata;
            if (paddr == A_IEN)  ien_q  <= pwdata[EV_W-1:0];
        end
    end

    // ========================================================
    // Counter channels: 1 is the divide-by-N, 2 the baud generator
    wire              run      = ctrl_q[C_RUN];
    wire              per_mode = ctrl_q[C_PERIOD];
    wire              gate     = (mst_q == M_GATE);
    wire [CNT_W-1:0]  baud_n   = rfc_baud_div(sw_f_q, CLK_FREQ);
    logic ch1_tick, ch2_tick, rt_tick;
    rfc_div #(.W(CNT_W)) u_ch1 (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (gate),
        .n       (ch1n_q),
        .tick    (ch1_tick)
    );
    rfc_div #(.W(CNT_W)) u_ch2 (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .n       (baud_n),
        .tick    (ch2_tick)
    );
    rfc_div #(.W(CNT_W)) u_rt (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .n       (CNT_W'(TICK_CNT)),
        .tick    (rt_tick)
    );

    // ========================================================
    // Gate source select: period gate counts channel 1 pulses between
    // reference edges; fixed gate counts reference edges for N cycles
    wire cnt_src  = per_mode ? ch1_tick : ref_edge;
    wire gate_end = gate & (per_mode ? ref_edge : ch1_tick);
    wire [CNT_W-1:0] cnt_nxt = cnt_q + CNT_W'(cnt_src);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_q  <= M_IDLE;
            cnt_q  <= '0;
            hold_q <= '0;
        end else begin
            case (mst_q)
                M_IDLE: begin
                    cnt_q <= '0;
                    // Period mode starts on an edge so the gate is whole
                    if (run && (!per_mode || ref_edge)) mst_q <= M_GATE;
                end
                M_GATE: begin
                    if (gate_end) begin
                        hold_q <= cnt_nxt;
                        cnt_q  <= '0;
                    end else begin
                        cnt_q  <= cnt_nxt;
                    end
                    // Stop after the capture so a gate end never drops
                    if (!run) mst_q <= M_IDLE;
                end
                default: mst_q <= M_IDLE;
            endcase
        end
    end

    // ========================================================
    // No-reference watchdog, retriggered by each reference edge
    logic [CNT_W-1:0] nr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nr_q   <= '0;
            no_ref <= 1'b0;
        end else if (ref_edge) begin
            nr_q   <= '0;
            no_ref <= 1'b0;
        end else if (nr_q + CNT_W'(1) >= CNT_W'(NOREF_CNT)) begin
            no_ref <= 1'b1;
        end else begin
            nr_q   <= nr_q + CNT_W'(1);
        end
    end

    // ========================================================
    // Receive byte holding; a late read loses the older byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_q              <= 8'h00;
            receive_byte_ready <= 1'b0;
            baud_x16           <= 1'b0;
        end else begin
            if (rx_byte_valid) rxd_q <= rx_byte;
            // Arrival wins over the read that clears it
            receive_byte_ready <= rx_byte_valid |
                                  (receive_byte_ready & ~rd_rxd);
            baud_x16 <= ch2_tick;
        end
    end

    // ========================================================
    // Sticky events, write-one clear, enable mask, level interrupt
    logic no_ref_p_q;
    rfc_evt_t ev;
    always_comb begin
        ev.tick    = rt_tick;
        ev.rx      = rx_byte_valid;
        ev.done    = gate_end & run;
        ev.noref   = no_ref & ~no_ref_p_q;
        ev.overrun = rx_byte_valid & receive_byte_ready & ~rd_rxd;
    end
    wire [EV_W-1:0] clr = (wr && paddr == A_CLR) ? pwdata[EV_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q      <= EV_RST;
            no_ref_p_q <= 1'b0;
            irq        <= 1'b0;
        end else begin
            sts_q      <= ev | (sts_q & ~clr);
            no_ref_p_q <= no_ref;
            irq        <= |(sts_q & ien_q);
        end
    end

    // ========================================================
    // Checks
    AST_BAUD: assert property (@(posedge pclk) disable iff (!presetn)
        ch2_tick |=> baud_x16 ##1 !baud_x16)
        else $error("baud pulse not one cycle");
    AST_BAUDN: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_f_q == 3'h0) |-> (baud_n == CNT_W'(CLK_FREQ / 4800)))
        else $error("300 baud divisor wrong");
    AST_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (mst_q == M_IDLE) |=> (cnt_q == '0))
        else $error("count moved outside gate");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        gate_end |=> (hold_q == $past(cnt_nxt)) && (cnt_q == '0))
        else $error("count not held at gate end");
    AST_FREQ: assert property (@(posedge pclk) disable iff (!presetn)
        (gate && !per_mode && ref_edge && !ch1_tick && run)
        |=> cnt_q == $past(cnt_q) + 1)
        else $error("reference edge not counted");
    AST_TICK: assert property (@(posedge pclk) disable iff (!presetn)
        rt_tick |=> sts_q[0])
        else $error("tick not recorded");
    AST_RECEIVE_BYTE_READY: assert property (@(posedge pclk) disable iff (!presetn)
        rx_byte_valid |=> receive_byte_ready && sts_q[1])
        else $error("received byte not flagged");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (sts_q[1] && ien_q[1]) |=> irq)
        else $error("enabled event gave no interrupt");
    AST_NOREF: assert property (@(posedge pclk) disable iff (!presetn)
        ref_edge |=> !no_ref ##1 !no_ref)
        else $error("no-reference not retriggered");
    AST_SLV: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !hit) |=> pready && pslverr)
        else $error("unmapped access not refused");
    AST_RDCLR: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_rxd && !rx_byte_valid) |=> !receive_byte_ready)
        else $error("read did not clear byte ready");
    AST_OVR: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_byte_valid && receive_byte_ready && !rd_rxd) |=> sts_q[4])
        else $error("overwritten byte not flagged");
    AST_NRSET: assert property (@(posedge pclk) disable iff (!presetn)
        (!ref_edge && (nr_q + CNT_W'(1) >= CNT_W'(NOREF_CNT))) |=> no_ref)
        else $error("no-reference not raised");
    AST_NREV: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(no_ref) |=> sts_q[3])
        else $error("no-reference event not recorded");
    AST_PER: assert property (@(posedge pclk) disable iff (!presetn)
        (gate && per_mode && ch1_tick && !ref_edge && run)
        |=> cnt_q == $past(cnt_q) + 1)
        else $error("divided pulse not counted");
    AST_TKGAP: assert property (@(posedge pclk) disable iff (!presetn)
        rt_tick |=> !rt_tick)
        else $error("tick pulse too long");
    AST_TKCLR: assert property (@(posedge pclk) disable iff (!presetn)
        (clr[0] && !rt_tick) |=> !sts_q[0])
        else $error("tick status not cleared");
    AST_IRQLO: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(sts_q & ien_q)) |=> !irq)
        else $error("interrupt without enabled event");
endmodule
`default_nettype wire

//--- test/rfc_cpu_model.sv
// Processor-side model: bus master that reads and programs the counter
`timescale 1ns/1ps
`default_nettype none
module rfc_cpu_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    // ==========================================
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic ok);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        r = prdata;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data inverted, so stale words never pass for fresh
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- test/reference_freq_counter_tb_top.sv
// Self-checking bench of the reference frequency counter
`timescale 1ns/1ps
`default_nettype none
module reference_freq_counter_tb_top;
    import rfc_pkg::*;
    // Short counts keep the run brief
    localparam int unsigned FQ = 1_000_000;
    localparam int unsigned TK = 50;
    localparam int unsigned NR = 200;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite;
    logic        pready, pslverr, ref_in = 1'b0, ref_en = 1'b0, ok;
    logic        rx_byte_valid = 1'b0, baud_x16, receive_byte_ready;
    logic        no_ref, irq;
    logic [7:0]  paddr, rx_byte = 8'h00;
    logic [2:0]  baud_sw = 3'h0, rc = 3'h0;
    logic [31:0] pwdata, prdata, rd_v, nn;
    logic [33:0] exp_q[$], e;
    int          error_cnt = 0, samples_checked = 0, cyc = 0, seed = 11;
    int          n, t0;
    rfc_top #(.CLK_FREQ(FQ), .TICK_CNT(TK), .NOREF_CNT(NR)) i_rfc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_in(ref_in),
        .baud_sw(baud_sw), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .baud_x16(baud_x16),
        .receive_byte_ready(receive_byte_ready), .no_ref(no_ref),
        .irq(irq));
    rfc_cpu_model i_cpu (
        .pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    // ==========================================
    // Clock, reference of ten cycles, cycle count and hang limit
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        rc <= (rc == 3'h4) ? 3'h0 : rc + 3'h1;
        if (ref_en && rc == 3'h4) ref_in <= ~ref_in;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input logic [32:0] g, input logic [32:0] x);
        samples_checked++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // Oldest note against each bus answer; bit 32 says data matters
    always @(posedge pclk) begin
        if (presetn && pready === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            chk({pslverr, prdata}, {e[33], e[32] ? e[31:0] : prdata});
        end
    end
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        exp_q.push_back(x);
        i_cpu.xfer(w, a, d, rd_v, ok);
        chk(33'(ok), 33'h1);
    endtask
    // Bounded wait: 0 irq high, 1 baud pulse, 2 irq low
    task automatic wait_for(input int k);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(k == 0 ? irq === 1'b1 : k == 1 ? baud_x16 === 1'b1
                     : irq === 1'b0) && n < 400);
        chk(33'(n < 400), 33'h1);
    endtask
    // Fresh gate end, then the held count
    task automatic measure(input int lo, input int hi);
        acc(1'b1, A_CLR, 32'h4, 34'h0);
        repeat (60) begin
            acc(1'b0, A_STS, 32'h0, 34'h0);
            if (rd_v[2]) break;
        end
        chk(33'(rd_v[2]), 33'h1);
        acc(1'b0, A_COUNT, 32'h0, 34'h0);
        chk(33'(rd_v >= lo && rd_v <= hi), 33'h1);
    endtask
    task automatic close_out;
        $display("Errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, A_CTRL, 32'h0, {2'b01, 30'h0, CTRL_RST});
        acc(1'b0, A_CH1N, 32'h0, {2'b01, CH1N_RST});
        acc(1'b0, A_IEN, 32'h0, {2'b01, 27'h0, EV_RST});
        acc(1'b1, 8'h20, 32'hffff_ffff, {2'b11, 32'h0});
        acc(1'b0, 8'h20, 32'h0, {2'b11, 32'h0});
        // Received byte, read, then overwrite without reading
        rx_byte <= 8'($random(seed));
        rx_byte_valid <= 1'b1;
        @(posedge pclk);
        rx_byte_valid <= 1'b0;
        @(posedge pclk);
        chk(33'(receive_byte_ready), 33'h1);
        acc(1'b0, A_RXD, 32'h0, {2'b01, 24'h0, rx_byte});
        @(posedge pclk);
        chk(33'(receive_byte_ready), 33'h0);
        repeat (2) begin
            rx_byte <= 8'($random(seed));
            rx_byte_valid <= 1'b1;
            @(posedge pclk);
            rx_byte_valid <= 1'b0;
            @(posedge pclk);
        end
        acc(1'b0, A_STS, 32'h0, 34'h0);
        chk(33'({rd_v[4], rd_v[1]}), 33'h3);
        acc(1'b0, A_RXD, 32'h0, {2'b01, 24'h0, rx_byte});
        // Tick spacing through the interrupt, then masked
        acc(1'b1, A_IEN, 32'h1, 34'h0);
        acc(1'b1, A_CLR, 32'h1f, 34'h0);
        wait_for(2);
        wait_for(0);
        t0 = cyc;
        acc(1'b1, A_CLR, 32'h1, 34'h0);
        wait_for(2);
        wait_for(0);
        chk(33'(cyc - t0), 33'(TK));
        acc(1'b1, A_IEN, 32'h0, 34'h0);
        repeat (TK + 5) @(posedge pclk);
        chk(33'(irq), 33'h0);
        acc(1'b0, A_STS, 32'h0, 34'h0);
        chk(33'(rd_v[0]), 33'h1);
        // Every switch code, x16 pulse spacing
        for (int s = 0; s < 8; s++) begin
            baud_sw <= 3'(s);
            repeat (10) @(posedge pclk);
            wait_for(1);
            wait_for(1);
            t0 = cyc;
            wait_for(1);
            nn = 32'(FQ / (BAUD_OVS * (BAUD_MIN << (s > 6 ? 6 : s))));
            chk(33'(cyc - t0), 33'(nn));
        end
        chk(33'(no_ref), 33'h1);
        ref_en <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(33'(no_ref), 33'h0);
        // Frequency gate of random length, then period mode
        nn = 40 + ($unsigned($random(seed)) % 40);
        acc(1'b1, A_CH1N, nn, 34'h0);
        acc(1'b1, A_CTRL, 32'h1, 34'h0);
        measure(nn / 10 - 1, nn / 10 + 1);
        // Stop first so no partial gate of the old mode is held
        acc(1'b1, A_CTRL, 32'h0, 34'h0);
        acc(1'b1, A_CH1N, 32'h2, 34'h0);
        acc(1'b1, A_CTRL, 32'h3, 34'h0);
        measure(4, 6);
        acc(1'b1, A_CTRL, 32'h0, 34'h0);
        ref_en <= 1'b0;
        repeat (NR - 30) @(posedge pclk);
        chk(33'(no_ref), 33'h0);
        repeat (60) @(posedge pclk);
        chk(33'(no_ref), 33'h1);
        acc(1'b0, A_LEVEL, 32'h0, {2'b01, 32'h1});
        close_out();
    end
endmodule
`default_nettype wire
